//--- logic/write_wait_refetch_ctrl.sv
// Write-wait and instruction re-fetch inhibit control registers with their APB slave.
//
// Summary of operation
// - Eight write-wait bits, uncached or write-through writes only.
// - Bit clear: next access does not wait.
// - Bit set: next access waits for write.
// - Bit 7 control area, bits 6-0 areas.
// - After reset every covered change forces re-fetch.
// - Inhibit 0 re-fetches, inhibit 1 suppresses it.
// - Bit 4 covers five control register writes.
// - Bit 3 covers control window register writes.
// - Bit 2 covers TLB load instruction execution.
// - Bit 1 covers mapped TLB writes when translating.
// - Bit 0 covers mapped icache writes when enabled.
// - Mapping enable off 0, on 1, qualifies bit 1.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "write_wait_refetch_params.svh"

module write_wait_refetch_ctrl (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic PREADY_O,
	output logic [31:0] PRDATA_O,
	output logic PSLVERR_O,
	// Bus interface side
	input wire write_wait_refetch_pkg::buf_write_t BUF_WR_I,
	output logic BUS_HOLD_O,
	// Fetch pipeline side
	input wire write_wait_refetch_pkg::refetch_evt_t REFETCH_EVT_I,
	input wire logic VIRT_MAPPING_ON_I,
	input wire logic ICACHE_ENABLE_I,
	output logic REFETCH_O,
	output logic [4:0] REFETCH_CAUSE_O
);

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	function automatic logic [1:0] reg_sel(input logic [11:0] addr);
		if (addr == `WWR_OFS_PHYS_WR_CTRL) begin
			reg_sel = 2'h1;
		end else if (addr == `WWR_OFS_REFETCH_CTRL) begin
			reg_sel = 2'h2;
		end else if (addr == `WWR_OFS_STATUS) begin
			reg_sel = 2'h3;
		end else begin
			reg_sel = 2'h0;
		end
	endfunction : reg_sel

	function automatic logic in_window(input logic [31:0] addr);
		in_window = (addr >= `WWR_WIN_LO) && (addr <= `WWR_WIN_HI);
	endfunction : in_window

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [7:0] area_write_wait_ff;
	logic [7:0] nxt_area_write_wait;
	logic [4:0] inhibit_ff;
	logic [4:0] nxt_inhibit;
	logic pready_ff;
	logic nxt_pready;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pslverr_ff;
	logic nxt_pslverr;
	logic hold_ff;
	logic nxt_hold;
	logic refetch_ff;
	logic nxt_refetch;
	logic [4:0] cause_ff;
	logic [4:0] nxt_cause;
	logic [7:0] pending;
	logic [`WWR_PEND_CNT_W-1:0] pend_cnt_ff [`WWR_AREA_CNT];
	logic [`WWR_PEND_CNT_W-1:0] nxt_pend_cnt [`WWR_AREA_CNT];

	logic setup_phase;
	logic wr_commit;
	logic [1:0] sel_setup;
	logic [1:0] sel_access;
	logic [2:0] issue_area;
	logic issue_tracked;

	assign setup_phase = PSEL_I && !PENABLE_I;
	assign sel_setup = reg_sel(PADDR_I);
	assign sel_access = reg_sel(PADDR_I);
	// A write lands only at the edge where the access phase sees pready high.
	assign wr_commit = PSEL_I && PENABLE_I && pready_ff && PWRITE_I && !pslverr_ff;
	assign issue_area = BUF_WR_I.addr[`WWR_AREA_MSB:`WWR_AREA_LSB];
	// Copy-back writes never make the next access wait.
	assign issue_tracked = BUF_WR_I.issue && BUF_WR_I.bypass;

	// ------------------------------------------------------------------------
	// APB slave and register file
	// ------------------------------------------------------------------------
	always_comb begin
		nxt_area_write_wait = area_write_wait_ff;
		nxt_inhibit = inhibit_ff;
		nxt_pready = 1'b0;
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		if (setup_phase) begin
			// One wait-free answer: pready rises in the first access cycle.
			nxt_pready = 1'b1;
			nxt_pslverr = (sel_setup == 2'h0) || (PWRITE_I && sel_setup == 2'h3);
			nxt_prdata = 32'h00000000;
			if (!PWRITE_I) begin
				if (sel_setup == 2'h1) begin
					nxt_prdata = {24'h000000, area_write_wait_ff};
				end else if (sel_setup == 2'h2) begin
					nxt_prdata = {27'h0000000, inhibit_ff};
				end else if (sel_setup == 2'h3) begin
					nxt_prdata = {23'h000000, hold_ff, pending};
				end
			end
		end else if (PSEL_I && PENABLE_I && !pready_ff) begin
			nxt_pready = 1'b1;
			nxt_pslverr = pslverr_ff;
		end
		// Only the low byte lane carries writable bits.
		if (wr_commit && PSTRB_I[0]) begin
			if (sel_access == 2'h1) begin
				nxt_area_write_wait = PWDATA_I[7:0];
			end else if (sel_access == 2'h2) begin
				nxt_inhibit = PWDATA_I[4:0];
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			area_write_wait_ff <= `WWR_RST_PHYS_WR_CTRL;
			inhibit_ff <= `WWR_RST_REFETCH_CTRL;
			pready_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else begin
			area_write_wait_ff <= nxt_area_write_wait;
			inhibit_ff <= nxt_inhibit;
			pready_ff <= nxt_pready;
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// ------------------------------------------------------------------------
	// Outstanding buffered writes per 64-Mbyte area
	// ------------------------------------------------------------------------
	// A counter rather than a flag keeps two overlapping writes to one area
	// from releasing the hold when only the first has retired.
	genvar g;
	generate
		for (g = 0; g < `WWR_AREA_CNT; g++) begin : g_area
			logic inc;
			logic dec;
			assign inc = issue_tracked && (issue_area == 3'(g));
			assign dec = BUF_WR_I.done && (BUF_WR_I.done_area == 3'(g))
				&& (pend_cnt_ff[g] != 3'h0);
			always_comb begin
				nxt_pend_cnt[g] = pend_cnt_ff[g];
				if (inc && !dec) begin
					nxt_pend_cnt[g] = pend_cnt_ff[g] + 3'h1;
				end else if (dec && !inc) begin
					nxt_pend_cnt[g] = pend_cnt_ff[g] - 3'h1;
				end
			end
			always_ff @(posedge CLK_I) begin
				if (SYS_RST_I) begin
					pend_cnt_ff[g] <= 3'h0;
				end else begin
					pend_cnt_ff[g] <= nxt_pend_cnt[g];
				end
			end
			assign pending[g] = (pend_cnt_ff[g] != 3'h0);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Bus hold towards the bus interface
	// ------------------------------------------------------------------------
	always_comb begin
		nxt_hold = 1'b0;
		for (int i = 0; i < `WWR_AREA_CNT; i++) begin
			// Waited areas hold the next access; unwaited ones never do.
			if ((nxt_pend_cnt[i] != 3'h0) && nxt_area_write_wait[i]) begin
				nxt_hold = 1'b1;
			end
		end
		// An area with its bit clear contributes nothing to the hold.
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			hold_ff <= 1'b0;
		end else begin
			hold_ff <= nxt_hold;
		end
	end

	// ------------------------------------------------------------------------
	// Re-fetch request towards the fetch pipeline
	// ------------------------------------------------------------------------
	logic [4:0] change;
	logic phys_wr_ctrl_commit;

	// A write to the physical space write control register is one of the five
	// group registers, so it raises the group event by itself.
	assign phys_wr_ctrl_commit = wr_commit && (sel_access == 2'h1);

	always_comb begin
		change = 5'h00;
		change[`WWR_INH_REG_GROUP_B] = REFETCH_EVT_I.reg_group_b_wr
			|| phys_wr_ctrl_commit;
		change[`WWR_INH_PERIPH_WIN] = REFETCH_EVT_I.win_wr
			&& in_window(REFETCH_EVT_I.win_addr);
		change[`WWR_INH_TLB_LOAD] = REFETCH_EVT_I.tlb_load;
		change[`WWR_INH_MAPPED_TLB] = REFETCH_EVT_I.mapped_tlb_wr
			&& VIRT_MAPPING_ON_I;
		change[`WWR_INH_MAPPED_IC] = REFETCH_EVT_I.mapped_icache_wr
			&& ICACHE_ENABLE_I;
		nxt_cause = change & ~inhibit_ff;
		nxt_refetch = |nxt_cause;
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			refetch_ff <= 1'b0;
			cause_ff <= 5'h00;
		end else begin
			refetch_ff <= nxt_refetch;
			cause_ff <= nxt_cause;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign PREADY_O = pready_ff;
	assign PRDATA_O = prdata_ff;
	assign PSLVERR_O = pslverr_ff;
	assign BUS_HOLD_O = hold_ff;
	assign REFETCH_O = refetch_ff;
	assign REFETCH_CAUSE_O = cause_ff;

endmodule : write_wait_refetch_ctrl

//--- logic/write_wait_refetch_params.svh
// Register offsets, field positions, reset values and address bounds of the write-wait block.
`ifndef WRITE_WAIT_REFETCH_PARAMS_SVH
`define WRITE_WAIT_REFETCH_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------------------------------------------
`define WWR_OFS_PHYS_WR_CTRL 12'h000
`define WWR_OFS_REFETCH_CTRL 12'h004
`define WWR_OFS_STATUS 12'h008

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define WWR_AREA_CNT 8
`define WWR_AREA_MSB 28
`define WWR_AREA_LSB 26
`define WWR_INH_WIDTH 5
`define WWR_INH_MAPPED_IC 0
`define WWR_INH_MAPPED_TLB 1
`define WWR_INH_TLB_LOAD 2
`define WWR_INH_PERIPH_WIN 3
`define WWR_INH_REG_GROUP_B 4
`define WWR_STAT_HOLD_BIT 8
`define WWR_PEND_CNT_W 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define WWR_RST_PHYS_WR_CTRL 8'h00
`define WWR_RST_REFETCH_CTRL 5'h00

// ----------------------------------------------------------------------------
// Control address window whose register writes may force a re-fetch
// ----------------------------------------------------------------------------
`define WWR_WIN_LO 32'hFF200000
`define WWR_WIN_HI 32'hFF2FFFFF

`endif

//--- logic/write_wait_refetch_pkg.sv
// Types shared by the write-wait and re-fetch control block.
package write_wait_refetch_pkg;

	// Resource-change events reported by the CPU pipeline, each a one-cycle pulse.
	typedef struct packed {
		logic reg_group_b_wr;
		logic win_wr;
		logic [31:0] win_addr;
		logic tlb_load;
		logic mapped_tlb_wr;
		logic mapped_icache_wr;
	} refetch_evt_t;

	// A buffered write as issued or retired by the bus interface.
	typedef struct packed {
		logic issue;
		logic bypass;
		logic [31:0] addr;
		logic done;
		logic [2:0] done_area;
	} buf_write_t;

endpackage : write_wait_refetch_pkg

//--- verification/write_wait_refetch_partner.sv
// Model of the fetch pipeline and bus interface that raise event and write pulses.
`timescale 1ns/1ps
module write_wait_refetch_partner (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Requests from the bench
	input wire write_wait_refetch_pkg::refetch_evt_t evt_req_i,
	input wire write_wait_refetch_pkg::buf_write_t buf_req_i,
	// Pulses toward the block
	output write_wait_refetch_pkg::refetch_evt_t evt_o,
	output write_wait_refetch_pkg::buf_write_t buf_o
);
	// Idle addresses toggle, so a stale address can never pass for a live one.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_o <= '0;
			buf_o <= '0;
		end else begin
			evt_o <= evt_req_i;
			buf_o <= buf_req_i;
			if (!evt_req_i.win_wr) evt_o.win_addr <= ~evt_o.win_addr;
			if (!buf_req_i.issue) buf_o.addr <= ~buf_o.addr;
		end
	end
endmodule : write_wait_refetch_partner

//--- verification/write_wait_refetch_ctrl_sva.sv
// Port checks of the write-wait and re-fetch block.
`timescale 1ns/1ps
`include "write_wait_refetch_params.svh"
module write_wait_refetch_ctrl_sva (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	// APB
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic PREADY_O,
	input wire logic [31:0] PRDATA_O,
	input wire logic PSLVERR_O,
	// Bus and fetch sides
	input wire write_wait_refetch_pkg::buf_write_t BUF_WR_I,
	input wire logic BUS_HOLD_O,
	input wire write_wait_refetch_pkg::refetch_evt_t REFETCH_EVT_I,
	input wire logic VIRT_MAPPING_ON_I,
	input wire logic ICACHE_ENABLE_I,
	input wire logic REFETCH_O,
	input wire logic [4:0] REFETCH_CAUSE_O
);
	logic setup, in_win, wr_done;
	assign setup = PSEL_I && !PENABLE_I;
	assign wr_done = PREADY_O && PWRITE_I;
	assign in_win = REFETCH_EVT_I.win_wr && REFETCH_EVT_I.win_addr >= `WWR_WIN_LO
		&& REFETCH_EVT_I.win_addr <= `WWR_WIN_HI;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	a_ready_answer: assert property (setup |=> PREADY_O) else $error("no ready");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("long ready");
	a_unmapped_err: assert property (setup && PADDR_I > 12'h008 |=> PSLVERR_O
		&& PRDATA_O == 32'h0) else $error("unmapped access");
	a_cause_window: assert property (REFETCH_CAUSE_O[3] |-> $past(in_win))
		else $error("window cause");
	a_cause_tlbload: assert property (REFETCH_CAUSE_O[2] |-> $past(REFETCH_EVT_I.tlb_load))
		else $error("tlb load cause");
	a_cause_maptlb: assert property (REFETCH_CAUSE_O[1] |->
		$past(REFETCH_EVT_I.mapped_tlb_wr && VIRT_MAPPING_ON_I)) else $error("tlb cause");
	a_cause_icache: assert property (REFETCH_CAUSE_O[0] |->
		$past(REFETCH_EVT_I.mapped_icache_wr && ICACHE_ENABLE_I)) else $error("icache cause");
	a_refetch_flag: assert property (REFETCH_O == (REFETCH_CAUSE_O != 5'h00))
		else $error("flag and cause differ");
	a_hold_rise: assert property ($rose(BUS_HOLD_O) |->
		$past(BUF_WR_I.issue && BUF_WR_I.bypass) || $past(wr_done) || $past(wr_done, 2))
		else $error("hold without cause");
	c_hold: cover property (BUS_HOLD_O);
	c_all_causes: cover property (REFETCH_CAUSE_O == 5'h1F);
	c_slverr: cover property (PREADY_O && PSLVERR_O);
endmodule : write_wait_refetch_ctrl_sva

//--- verification/write_wait_refetch_ctrl_test.sv
// Register, bus-hold and re-fetch tests of the write-wait block.
`timescale 1ns/1ps
module write_wait_refetch_ctrl_test;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, virt = 1'b1, icache_enable = 1'b1;
	logic prdy, perr, er, hold, rf;
	logic [4:0] cause;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	write_wait_refetch_pkg::refetch_evt_t ereq = '0, evt;
	write_wait_refetch_pkg::buf_write_t breq = '0, bwr;
	int error_cnt = 0, checks = 0;
	initial forever #25 clk = ~clk;
	write_wait_refetch_partner u_far (.clk_i(clk), .rst_i(rst), .evt_req_i(ereq),
		.buf_req_i(breq), .evt_o(evt), .buf_o(bwr));
	write_wait_refetch_ctrl u_dut (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(4'hF),
		.PREADY_O(prdy), .PRDATA_O(prd), .PSLVERR_O(perr), .BUF_WR_I(bwr), .BUS_HOLD_O(hold),
		.REFETCH_EVT_I(evt), .VIRT_MAPPING_ON_I(virt), .ICACHE_ENABLE_I(icache_enable),
		.REFETCH_O(rf), .REFETCH_CAUSE_O(cause));
	task summarize;
		if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 20 && prdy !== 1'b1; n++) @(posedge clk);
		rd = prd;
		er = perr;
		{psel, pen} <= 2'b00;
		if (n == 20) begin
			chk(32'h0, 32'h1);
			summarize();
		end
	endtask : apb
	task pulse(input write_wait_refetch_pkg::refetch_evt_t e,
		input write_wait_refetch_pkg::buf_write_t b);
		@(posedge clk);
		{ereq, breq} <= {e, b};
		@(posedge clk);
		{ereq, breq} <= '0;
		@(posedge clk);
		@(negedge clk);
	endtask : pulse
	task ev(input logic g, input logic w, input logic [31:0] ad, input logic [2:0] tmc,
		input logic [4:0] x);
		pulse({g, w, ad, tmc}, '0);
		chk({26'h0, rf, cause}, {26'h0, x != 5'h00, x});
	endtask : ev
	task bw(input logic iss, input logic byp, input logic [2:0] ar, input logic dn, input logic h);
		pulse('0, {iss, byp, 3'h0, ar, 26'h0, dn, ar});
		chk({31'h0, hold}, {31'h0, h});
	endtask : bw
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		ev(1'b1, 1'b0, 32'h0, 3'h0, 5'h10);
		ev(1'b0, 1'b1, 32'hFF200000, 3'h0, 5'h08);
		ev(1'b0, 1'b1, 32'hFF2FFFFF, 3'h0, 5'h08);
		ev(1'b0, 1'b1, 32'hFF300000, 3'h0, 5'h00);
		ev(1'b0, 1'b0, 32'h0, 3'h4, 5'h04);
		ev(1'b0, 1'b0, 32'h0, 3'h2, 5'h02);
		ev(1'b0, 1'b0, 32'h0, 3'h1, 5'h01);
		ev(1'b1, 1'b1, 32'hFF2ABCDE, 3'h7, 5'h1F);
		@(posedge clk);
		{virt, icache_enable} <= 2'b00;
		ev(1'b0, 1'b0, 32'h0, 3'h2, 5'h00);
		ev(1'b0, 1'b0, 32'h0, 3'h1, 5'h00);
		apb(1'b1, 12'h004, 32'hFFFFFFFF);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h1F);
		ev(1'b1, 1'b1, 32'hFF200000, 3'h7, 5'h00);
		apb(1'b1, 12'h000, 32'hFFFFFFFF);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'hFF);
		apb(1'b0, 12'h00C, 32'h0);
		chk({31'h0, er} | rd, 32'h1);
		apb(1'b1, 12'h008, 32'h0);
		chk({31'h0, er}, 32'h1);
		bw(1'b1, 1'b0, 3'h5, 1'b0, 1'b0);
		for (int a = 0; a < 8; a++) begin
			apb(1'b1, 12'h000, 32'h1 << a);
			bw(1'b1, 1'b1, 3'(a), 1'b0, 1'b1);
			apb(1'b0, 12'h008, 32'h0);
			chk(rd, 32'h100 | (32'h1 << a));
			bw(1'b0, 1'b0, 3'(a), 1'b1, 1'b0);
			bw(1'b1, 1'b1, 3'(a + 1), 1'b0, 1'b0);
			bw(1'b0, 1'b0, 3'(a + 1), 1'b1, 1'b0);
		end
		summarize();
	end
endmodule : write_wait_refetch_ctrl_test
bind write_wait_refetch_ctrl write_wait_refetch_ctrl_sva u_sva (.CLK_I(CLK_I),
	.SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I), .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
	.BUF_WR_I(BUF_WR_I), .BUS_HOLD_O(BUS_HOLD_O), .REFETCH_EVT_I(REFETCH_EVT_I),
	.VIRT_MAPPING_ON_I(VIRT_MAPPING_ON_I), .ICACHE_ENABLE_I(ICACHE_ENABLE_I),
	.REFETCH_O(REFETCH_O), .REFETCH_CAUSE_O(REFETCH_CAUSE_O));
